// ### wlspb_ctrl.sv
/*
  White LED sink PWM generator and boost control, Wishbone slave.
  Assumes a classic Wishbone master on sys_clk and asynchronous
  fault levels from the boost analog stage.
*/
`timescale 1ns/10ps
`include "wlspb_defs.svh"

module wlspb_ctrl #(
  parameter int GLIDE_CYC = `WLSPB_GLIDE_CYC,
  parameter int FADE_CYC = `WLSPB_FADE_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic overvolt_async,
  input wire logic overcurrent_async,
  output wlspb_pkg::wlspb_sink_t [2:0] sink_drive,
  output wlspb_pkg::wlspb_boost_t boost,
  output logic interrupt_out_n
);

  localparam int STEP_CYC = `WLSPB_STEP_CYC;
  localparam int SW = $clog2(STEP_CYC);
  localparam int GW = $clog2(GLIDE_CYC);
  localparam int FW = $clog2(FADE_CYC);

  // ========================================================
  // Duty shaping
  // Effective high steps of a duty code
  function automatic logic [6:0] eff_duty(input logic [6:0] code,
                                          input logic pwm_only);
    logic [6:0] r;
    r = code;
    if (code >= `WLSPB_PERIOD) begin
      r = `WLSPB_PERIOD;
    end else if (!pwm_only && code != `WLSPB_DUTY_OFF &&
                 code < `WLSPB_MIN_DUTY) begin
      r = `WLSPB_MIN_DUTY;
    end
    return r;
  endfunction

  // One fade step from present toward target
  function automatic logic [6:0] fade_step(input logic [6:0] cur,
                                           input logic [6:0] tgt,
                                           input logic pwm_only);
    logic [6:0] r;
    r = cur;
    if (tgt > cur) begin
      r = cur + 7'h01;
    end else if (tgt < cur) begin
      r = cur - 7'h01;
    end
    // Current mode skips the unused codes below the minimum
    if (!pwm_only && r != `WLSPB_DUTY_OFF && r < `WLSPB_MIN_DUTY) begin
      r = (tgt < cur) ? `WLSPB_DUTY_OFF : `WLSPB_MIN_DUTY;
    end
    return r;
  endfunction

  // ========================================================
  // Bus and register state
  logic ack_r;
  logic [31:0] dat_r;
  logic [6:0] boost_r;
  logic fault_r;
  logic [7:0] led_ctl_r;
  logic [7:0] led_ctl_nxt;
  logic [7:0] idle_r;
  logic [7:0] cur_tgt_r [3];
  logic [7:0] duty_r [3];
  logic [7:0] idx;
  logic req;
  logic wr;
  logic [2:0] sink_en;
  logic [2:0] pwm_hi;
  logic pwm_only_c;
  logic ov_lvl_r;
  logic oc_lvl_r;
  logic [2:0] ov_s_r;
  logic [2:0] oc_s_r;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & ack_r & wb_sel_i[0];
  assign pwm_only_c = ~led_ctl_r[`WLSPB_L_CMODE];
  assign sink_en = {led_ctl_r[4], led_ctl_r[2], led_ctl_r[0]};

  // Acknowledge one cycle after request, dropped the next
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // Read data, captured while the request waits
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dat_r <= 32'h0000_0000;
    end else if (req & ~ack_r) begin
      dat_r <= 32'h0000_0000;
      if (idx == `WLSPB_IDX_BOOST) begin
        dat_r[7:0] <= {fault_r, boost_r};
      end else if (idx == `WLSPB_IDX_LEDCTL) begin
        dat_r[7:0] <= led_ctl_r;
      end else if (idx == `WLSPB_IDX_IDLE) begin
        dat_r[7:0] <= idle_r;
      end else if (idx >= `WLSPB_IDX_CUR0 &&
                   idx < `WLSPB_IDX_DUTY0) begin
        dat_r[7:0] <= cur_tgt_r[idx[1:0] - 2'h1];
      end else if (idx >= `WLSPB_IDX_DUTY0 &&
                   idx < `WLSPB_IDX_STATUS) begin
        dat_r[7:0] <= duty_r[idx[1:0]];
      end else if (idx == `WLSPB_IDX_STATUS) begin
        dat_r[7:0] <= {4'h0, pwm_hi, boost.run};
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // LED control next value; PWM-only mode forces the string c enable bit off
  always_comb begin
    led_ctl_nxt = led_ctl_r;
    if (wr && idx == `WLSPB_IDX_LEDCTL) begin
      led_ctl_nxt = wb_dat_i[7:0];
    end
    if (!led_ctl_nxt[`WLSPB_L_CMODE]) begin
      led_ctl_nxt[4] = 1'b0;
    end
  end

  // LED control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      led_ctl_r <= `WLSPB_LEDCTL_RST;
    end else begin
      led_ctl_r <= led_ctl_nxt;
    end
  end

  // Boost control register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      boost_r <= `WLSPB_BOOST_RST;
    end else begin
      if (wr && idx == `WLSPB_IDX_BOOST) begin
        boost_r <= wb_dat_i[6:0];
      end
      for (int i = 0; i < 3; i++) begin
        if (!led_ctl_nxt[2*i]) begin
          boost_r[`WLSPB_B_FB_LO + i] <= 1'b0;
        end
      end
    end
  end

  // Current and duty registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_r <= 8'h00;
      for (int i = 0; i < 3; i++) begin
        cur_tgt_r[i] <= 8'h00;
        duty_r[i] <= 8'h00;
      end
    end else if (wr) begin
      if (idx == `WLSPB_IDX_IDLE) begin
        idle_r <= wb_dat_i[7:0];
      end else if (idx >= `WLSPB_IDX_CUR0 &&
                   idx < `WLSPB_IDX_DUTY0) begin
        cur_tgt_r[idx[1:0] - 2'h1] <= wb_dat_i[7:0];
      end else if (idx >= `WLSPB_IDX_DUTY0 &&
                   idx < `WLSPB_IDX_STATUS) begin
        duty_r[idx[1:0]] <= wb_dat_i[7:0];
      end
    end
  end

  // ========================================================
  // Fault inputs
  // Three-stage synchronisers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ov_s_r <= 3'h0;
      oc_s_r <= 3'h0;
    end else begin
      ov_s_r <= {ov_s_r[1:0], overvolt_async};
      oc_s_r <= {oc_s_r[1:0], overcurrent_async};
    end
  end

  // Levels change once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ov_lvl_r <= 1'b0;
      oc_lvl_r <= 1'b0;
    end else begin
      if (ov_s_r[1] == ov_s_r[2]) begin
        ov_lvl_r <= ov_s_r[2];
      end
      if (oc_s_r[1] == oc_s_r[2]) begin
        oc_lvl_r <= oc_s_r[2];
      end
    end
  end

  // Sticky fault, write one to bit 7 clears, a new event wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= (fault_r & ~(wr && idx == `WLSPB_IDX_BOOST &&
                  wb_dat_i[`WLSPB_B_FAULT])) | ov_lvl_r | oc_lvl_r;
    end
  end

  assign interrupt_out_n = ~(fault_r & ~boost_r[`WLSPB_B_MASK]);

  // ========================================================
  // Boost outputs
  always_comb begin
    boost.run = boost_r[`WLSPB_B_EN] & ~ov_lvl_r & ~oc_lvl_r;
    boost.feedback_include = boost_r[`WLSPB_B_FB_LO +: 3];
    boost.inductor_limit_select = boost_r[`WLSPB_B_ILIM];
    boost.switching_rate_select = boost_r[`WLSPB_B_FRQ];
    boost.current_drive_mode = led_ctl_r[`WLSPB_L_DRIVE];
  end

  // ========================================================
  // Time bases
  logic [SW-1:0] step_cnt_r;
  logic [GW-1:0] glide_cnt_r;
  logic [FW-1:0] fade_cnt_r;
  logic [6:0] phase_r;
  logic step_tick;
  logic glide_tick;
  logic fade_tick;
  assign step_tick = step_cnt_r == SW'(STEP_CYC - 1);
  assign glide_tick = glide_cnt_r == GW'(GLIDE_CYC - 1);
  assign fade_tick = fade_cnt_r == FW'(FADE_CYC - 1);
  // 2 MHz step, 1 ms glide and 40 ms fade dividers
  always_ff @(posedge sys_clk) begin
    step_cnt_r <= (sys_rst || step_tick) ? '0 : step_cnt_r + SW'(1);
    glide_cnt_r <= (sys_rst || glide_tick) ? '0 : glide_cnt_r + GW'(1);
    fade_cnt_r <= (sys_rst || fade_tick) ? '0 : fade_cnt_r + FW'(1);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_r <= 7'h00;
    end else if (step_tick) begin
      phase_r <= (phase_r == `WLSPB_PERIOD - 7'h01) ? 7'h00
                 : phase_r + 7'h01;
    end
  end

  // ========================================================
  // Per-string generators
  for (genvar g = 0; g < 3; g++) begin : g_str
    logic [6:0] duty_app_r;
    logic [6:0] tgt;
    logic [7:0] cur_app_r;
    logic only;

    assign only = (g == 2) && pwm_only_c;
    assign tgt = eff_duty(duty_r[g][6:0], only);

    // Applied duty, faded or immediate
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        duty_app_r <= 7'h00;
      end else if (!duty_r[g][`WLSPB_DUTY_FADE]) begin
        duty_app_r <= tgt;
      end else if (fade_tick) begin
        duty_app_r <= fade_step(duty_app_r, tgt, only);
      end
    end

    // Applied current, glided or immediate
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        cur_app_r <= 8'h00;
      end else if (!led_ctl_r[2*g+1]) begin
        cur_app_r <= cur_tgt_r[g];
      end else if (glide_tick) begin
        if (cur_tgt_r[g] > cur_app_r) begin
          cur_app_r <= cur_app_r + 8'h01;
        end else if (cur_tgt_r[g] < cur_app_r) begin
          cur_app_r <= cur_app_r - 8'h01;
        end
      end
    end

    assign pwm_hi[g] = (duty_app_r == `WLSPB_PERIOD) ||
                       (phase_r < duty_app_r);

    // Sink drive registered each cycle
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        sink_drive[g] <= '0;
      end else if (only) begin
        sink_drive[g].current_on <= 1'b0;
        sink_drive[g].switch_closed <= pwm_hi[g];
        sink_drive[g].level_code <= 8'h00;
      end else begin
        sink_drive[g].current_on <= sink_en[g];
        sink_drive[g].switch_closed <= sink_en[g] & pwm_hi[g];
        sink_drive[g].level_code <= pwm_hi[g] ? cur_app_r : idle_r;
      end
    end
  end

endmodule

// ### wlspb_defs.svh
/*
  Constants of the white LED sink PWM and boost control block.
  Assumes a 50 MHz system clock; included by bare name.
*/
`ifndef WLSPB_DEFS_SVH
`define WLSPB_DEFS_SVH

// ==========================================================
// Timing
`define WLSPB_CLK_HZ 50000000
`define WLSPB_STEP_HZ 2000000
`define WLSPB_STEP_CYC (`WLSPB_CLK_HZ / `WLSPB_STEP_HZ)
`define WLSPB_GLIDE_MS 1
`define WLSPB_GLIDE_CYC (`WLSPB_CLK_HZ / 1000 * `WLSPB_GLIDE_MS)
`define WLSPB_FADE_MS 40
`define WLSPB_FADE_CYC (`WLSPB_CLK_HZ / 1000 * `WLSPB_FADE_MS)

// ==========================================================
// Duty codes
`define WLSPB_PERIOD 7'h5F
`define WLSPB_MIN_DUTY 7'h10
`define WLSPB_DUTY_OFF 7'h00

// ==========================================================
// Register indexes, byte address is four times the index
`define WLSPB_IDX_BOOST 8'h46
`define WLSPB_IDX_LEDCTL 8'h47
`define WLSPB_IDX_IDLE 8'h48
`define WLSPB_IDX_CUR0 8'h49
`define WLSPB_IDX_DUTY0 8'h4C
`define WLSPB_IDX_STATUS 8'h4F

// ==========================================================
// Boost control fields
`define WLSPB_B_EN 0
`define WLSPB_B_FB_LO 1
`define WLSPB_B_ILIM 4
`define WLSPB_B_FRQ 5
`define WLSPB_B_MASK 6
`define WLSPB_B_FAULT 7
`define WLSPB_BOOST_RST 7'h00

// ==========================================================
// LED control fields: enable at 2*i, glide at 2*i+1
`define WLSPB_L_CMODE 6
`define WLSPB_L_DRIVE 7
`define WLSPB_LEDCTL_RST 8'hC0
`define WLSPB_DUTY_FADE 7

`endif

// ### wlspb_pkg.sv
/*
  Types of the white LED sink PWM and boost control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package wlspb_pkg;

  // Drive of one current sink toward the analog side
  typedef struct packed {
    logic current_on;
    logic switch_closed;
    logic [7:0] level_code;
  } wlspb_sink_t;

  // Controls of the boost converter
  typedef struct packed {
    logic run;
    logic [2:0] feedback_include;
    logic inductor_limit_select;
    logic switching_rate_select;
    logic current_drive_mode;
  } wlspb_boost_t;

endpackage

// ### wlspb_ctrl_properties.sv
/*
  Port checker of the LED sink and boost control block.
  Assumes a bind to wlspb_ctrl, one clock, sync reset.
*/
`timescale 1ns/10ps
// ==========
// Checker
module wlspb_ctrl_checker (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic overvolt_async,
  input wire logic overcurrent_async,
  input wire wlspb_pkg::wlspb_boost_t boost,
  input wire logic interrupt_out_n
);
  // Writes that commit at the ack edge
  logic wr_ok;
  logic wr_b;
  logic wr_l;
  assign wr_ok = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign wr_b = wr_ok && (wb_adr_i[9:2] == 8'h46);
  assign wr_l = wr_ok && (wb_adr_i[9:2] == 8'h47);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_ov_off;
    overvolt_async [*6] |-> !boost.run;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("boost runs in overvoltage");
  property p_oc_off;
    overcurrent_async [*6] |-> !boost.run;
  endproperty
  a_oc_off: assert property (p_oc_off)
    else $error("boost runs in overcurrent");
  property p_run_off;
    wr_b && !wb_dat_i[0] |=> !boost.run;
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("boost runs while disabled");
  property p_fb;
    wr_b |=> (boost.feedback_include & ~$past(wb_dat_i[3:1])) == 3'h0;
  endproperty
  a_fb: assert property (p_fb)
    else $error("excluded string in feedback");
  property p_limit;
    wr_b |=> boost.inductor_limit_select == $past(wb_dat_i[4]);
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit select wrong");
  property p_rate;
    wr_b |=> boost.switching_rate_select == $past(wb_dat_i[5]);
  endproperty
  a_rate: assert property (p_rate)
    else $error("rate select wrong");
  property p_mask;
    wr_b && wb_dat_i[6] |=> interrupt_out_n;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked fault drives interrupt");
  property p_en_fb;
    wr_l && !wb_dat_i[0] |=> !boost.feedback_include[0];
  endproperty
  a_en_fb: assert property (p_en_fb)
    else $error("disabled sink stays in feedback");
  // Main scenarios reached
  c_run: cover property ($rose(boost.run));
  c_irq: cover property (!interrupt_out_n);
  c_led: cover property (wr_l);
endmodule
bind wlspb_ctrl wlspb_ctrl_checker chk_u (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
  .overvolt_async(overvolt_async), .overcurrent_async(overcurrent_async),
  .boost(boost), .interrupt_out_n(interrupt_out_n));

// ### wlspb_host.sv
/*
  Host model: classic Wishbone master for the registers.
  Assumes a slave that answers with a registered ack.
*/
`timescale 1ns/10ps
// ==========
// Host bus master
module wlspb_host (
  input wire logic clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [11:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic ack,
  input wire logic [31:0] rdat
);
  // Idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 12'h000;
    sel = 4'h0;
    dat = 32'h0;
  end
  // One transfer held until ack; released lines invert
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'h0, i, 2'h0};
    sel <= 4'h1;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~{2'h0, i, 2'h0};
    dat <= ~{24'h0, d};
  endtask
endmodule

// ### white_led_sink_pwm_boost_ctrl_bench.sv
/*
  Bench of the LED sink PWM and boost control block.
  Assumes the host model and checker are compiled first.
*/
`timescale 1ns/10ps
// ==========
// Bench
module white_led_sink_pwm_boost_ctrl_bench;
  typedef struct {
    logic [7:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } wlspb_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ov = 1'b0;
  logic oc = 1'b0;
  logic cyc;
  logic stb;
  logic we;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic irq_n;
  logic [7:0] q;
  logic [7:0] lh;
  logic [7:0] ll;
  wlspb_pkg::wlspb_sink_t [2:0] sd;
  wlspb_pkg::wlspb_boost_t boost;
  int err_total = 0;
  int total_checks = 0;
  int hi;
  int per;
  wlspb_row_t rows [10] = '{'{8'h47, 8'hD5, 8'hD5},
    '{8'h48, 8'h11, 8'h11}, '{8'h49, 8'hA5, 8'hA5},
    '{8'h4A, 8'h5A, 8'h5A}, '{8'h4B, 8'h3C, 8'h3C},
    '{8'h4C, 8'h30, 8'h30}, '{8'h4D, 8'h05, 8'h05},
    '{8'h4E, 8'h60, 8'h60}, '{8'h46, 8'h7F, 8'h7F},
    '{8'h50, 8'hFF, 8'h00}};
  // Clock and units
  always #10 sys_clk = ~sys_clk;
  wlspb_host host_u (.clk(sys_clk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(wdat), .ack(ack), .rdat(rdat));
  wlspb_ctrl #(.GLIDE_CYC(20), .FADE_CYC(600)) dut_u (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .overvolt_async(ov), .overcurrent_async(oc),
    .sink_drive(sd), .boost(boost), .interrupt_out_n(irq_n));
  // ==========
  // Tasks
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    host_u.xfer(1'b1, i, d, q);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [7:0] e, string n);
    host_u.xfer(1'b0, i, 8'h00, q);
    check(n, q, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Count high time and period of one string
  task automatic measure(input int s);
    logic lo;
    lo = 1'b0;
    hi = 0;
    per = 0;
    while (sd[s].switch_closed !== 1'b0) @(negedge sys_clk);
    while (sd[s].switch_closed !== 1'b1) @(negedge sys_clk);
    while (!(lo && sd[s].switch_closed)) begin
      if (sd[s].switch_closed) begin
        hi++;
        lh = sd[s].level_code;
      end else begin
        lo = 1'b1;
        ll = sd[s].level_code;
      end
      per++;
      @(negedge sys_clk);
    end
  endtask
  task automatic hold(input int s, input logic v);
    int bad;
    bad = 0;
    repeat (2400) begin
      @(negedge sys_clk);
      if (sd[s].switch_closed !== v) bad++;
    end
    check("hold", bad, 0);
  endtask
  // ==========
  // Main sequence
  initial begin
    tick(4);
    sys_rst <= 1'b0;
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].w);
      rdc(rows[k].a, rows[k].r, "reg");
    end
    pause(1);
    check("boost", boost, 32'h7F);
    measure(0);
    check("hi_a", hi, 1200);
    check("per_a", per, 2375);
    check("lvl_hi", lh, 8'hA5);
    check("lvl_lo", ll, 8'h11);
    measure(1);
    check("hi_min", hi, 400);
    hold(2, 1'b1);
    wr(8'h4C, 8'h00);
    tick(2);
    hold(0, 1'b0);
    wr(8'h47, 8'h94);
    pause(1);
    check("fb", boost.feedback_include, 3'b010);
    pause(1);
    check("on", {sd[2].current_on, sd[1].current_on,
                 sd[0].current_on}, 3'h2);
    wr(8'h4E, 8'h05);
    measure(2);
    check("hi_c", hi, 125);
    wr(8'h4C, 8'h60);
    // glide set before the current change
    wr(8'h47, 8'h97);
    wr(8'h49, 8'hA8);
    pause(5);
    check("glide", sd[0].level_code < 8'hA7, 1'b1);
    pause(100);
    check("glide_end", sd[0].level_code, 8'hA8);
    wr(8'h4C, 8'h30);
    wr(8'h4C, 8'hA0);
    measure(0);
    check("fade", hi > 800, 1'b1);
    pause(10000);
    measure(0);
    check("fade_end", hi, 800);
    tick(1);
    oc <= 1'b1;
    pause(10);
    check("run_oc", boost.run, 1'b0);
    check("irq_mask", irq_n, 1'b1);
    tick(1);
    oc <= 1'b0;
    pause(10);
    check("run_back", boost.run, 1'b1);
    rdc(8'h46, 8'hF5, "fault");
    wr(8'h46, 8'h37);
    pause(1);
    check("irq", irq_n, 1'b0);
    wr(8'h46, 8'hB7);
    rdc(8'h46, 8'h37, "clear");
    ov <= 1'b1;
    pause(10);
    check("run_ov", boost.run, 1'b0);
    check("irq_ov", irq_n, 1'b0);
    tick(1);
    ov <= 1'b0;
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    pause(1);
    check("rst_sd", sd, 0);
    check("rst_boost", boost, 32'h01);
    check("rst_irq", irq_n, 1'b1);
    rdc(8'h47, 8'hC0, "rst_led");
    rdc(8'h46, 8'h00, "rst_reg");
    rdc(8'h4F, 8'h00, "rst_stat");
    wr(8'h46, 8'h7E);
    rdc(8'h46, 8'h70, "fb_off");
    check("run_off", boost.run, 1'b0);
    complete_run;
  end
  // Watchdog
  initial begin
    tick(95000);
    err_total++;
    complete_run;
  end
endmodule
